// File: verilog/hpc_device.sv
/*
  Device end of the host port: samples the control pins, decodes the target register,
  and carries out byte-pair reads and writes of control, address and data words.
  Assumes host pins are synchronous to sys_clk and the core side is a simple word port.
*/
// Functional notes
// - Byte-ident pin used only if strap high
// - Host marks first or second byte
// - Decode access code into target register
// - After reset control pins are inputs
// - Selected only while select low
// - Host waits for reset release
// - Read/write pin sets transfer direction
// - Address strobe latches address, multiplexed only
// - Ready output high after reset
// - Port disabled, outputs float when enable low
// - Host moves data with data strobes
`timescale 1ns/10ps
module hpc_device (
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              rst_b,
  // Straps and enable
  input  wire logic                              strap_select_pin,
  input  wire logic                              port_enable_in,
  // Host pins
  hpc_link_if.device                             link,
  // Core side
  input  wire logic [hpc_pkg::HPC_ADDR_W-1:0]     core_rdata,
  output logic      [hpc_pkg::HPC_ADDR_W-1:0]     core_addr,
  output logic      [hpc_pkg::HPC_ADDR_W-1:0]     core_wdata,
  output logic                                   core_wr,
  output logic                                   core_rd,
  output logic      [hpc_pkg::HPC_ADDR_W-1:0]     port_control_reg,
  output logic                                   mux_mode
);

  typedef enum logic [0:0] {
    HPC_ST_IDLE = 1'h0,
    HPC_ST_BUSY = 1'h1
  } hpc_dev_st_t;

  // Strap capture
  logic        strap_seen;
  logic        next_mux_mode;
  logic        strap_done;
  logic        next_strap_done;

  // Strobe edge and byte pairing
  logic        strobe_d;
  logic        strobe_now;
  logic        byte_sel;
  logic        first_byte;
  logic [7:0]  low_hold;
  logic [7:0]  next_low_hold;

  // Host-visible registers
  logic [15:0] port_address_reg;
  logic [15:0] next_address;
  logic [15:0] port_data_reg;
  logic [15:0] next_data;
  logic [15:0] next_control;

  // Next values of registered pins
  logic [7:0]  next_port_data;
  logic        next_port_data_oe;
  logic        next_ready;
  logic        next_ready_oe;

  // Core side and engine state
  logic        next_wr;
  logic        next_rd;
  logic [15:0] next_core_addr;
  hpc_dev_st_t state;
  hpc_dev_st_t next_state;
  hpc_pkg::hpc_sel_t sel;

  assign strap_seen = strap_select_pin;
  // Strobe is active when either data strobe is low; both low still counts as one strobe
  assign strobe_now = ~(link.data_strobe_one & link.data_strobe_two);
  // Without the strap the byte-ident pin is ignored and bytes alternate by count
  assign byte_sel   = mux_mode ? link.byte_ident_in : first_byte;
  assign sel        = hpc_pkg::hpc_sel_t'({link.access_ctrl_hi, link.access_ctrl_lo});
  // The data register doubles as the core write word, so no second copy is kept
  assign core_wdata = port_data_reg;

  // Strap capture once, on the first clock after reset release
  always_comb begin
    next_strap_done = 1'h1;
    next_mux_mode   = strap_done ? mux_mode : strap_seen;
  end

  // Strap flops; the captured mode sticks until the next reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_done <= 1'h0;
      mux_mode   <= 1'h0;
    end else begin
      strap_done <= next_strap_done;
      mux_mode   <= next_mux_mode;
    end
  end

  // Access engine: one byte per falling strobe edge, word completes on second byte
  always_comb begin
    next_state        = state;
    next_address      = port_address_reg;
    next_data         = port_data_reg;
    next_control      = port_control_reg;
    next_low_hold     = low_hold;
    next_port_data    = link.port_data;
    next_port_data_oe = 1'h0;
    next_ready        = hpc_pkg::HPC_READY_RESET;
    next_ready_oe     = port_enable_in;
    next_wr           = 1'h0;
    next_rd           = 1'h0;
    next_core_addr    = core_addr;
    // Address strobe is only honoured with the multiplexed strap;
    // an address-register write in the same cycle overrides it
    if (mux_mode && !link.address_strobe_in && port_enable_in && !link.port_select_n) begin
      next_address = {port_address_reg[7:0], link.host_data};
    end
    // Drive read data only while selected, enabled, reading and strobing
    if (port_enable_in && !link.port_select_n && link.read_write_sel == hpc_pkg::HPC_DIR_READ
        && strobe_now) begin
      next_port_data_oe = 1'h1;
      unique case (sel)
        hpc_pkg::HPC_SEL_CONTROL: next_port_data = byte_sel ? port_control_reg[15:8] : port_control_reg[7:0];
        hpc_pkg::HPC_SEL_ADDRESS: next_port_data = byte_sel ? port_address_reg[15:8] : port_address_reg[7:0];
        hpc_pkg::HPC_SEL_DATA_INC,
        hpc_pkg::HPC_SEL_DATA:    next_port_data = byte_sel ? core_rdata[15:8] : core_rdata[7:0];
      endcase
    end
    // Falling edge of the strobe pair takes one byte
    if (port_enable_in && !link.port_select_n && strobe_now && !strobe_d) begin
      // Core address is the one in force before any increment
      next_core_addr = port_address_reg;
      // First byte is parked until its partner arrives
      if (!byte_sel) begin
        next_low_hold = link.host_data;
        next_state    = hpc_dev_st_t'(HPC_ST_BUSY);
      end else begin
        next_state = HPC_ST_IDLE;
        // Word is {second byte, first byte}; registers change only on the second byte
        if (link.read_write_sel == hpc_pkg::HPC_DIR_WRITE) begin
          unique case (sel)
            hpc_pkg::HPC_SEL_CONTROL: next_control = {link.host_data, low_hold};
            hpc_pkg::HPC_SEL_ADDRESS: next_address = {link.host_data, low_hold};
            hpc_pkg::HPC_SEL_DATA_INC,
            hpc_pkg::HPC_SEL_DATA: begin
              next_data = {link.host_data, low_hold};
              next_wr   = 1'h1;
            end
          endcase
        end else if (sel == hpc_pkg::HPC_SEL_DATA_INC || sel == hpc_pkg::HPC_SEL_DATA) begin
          next_rd = 1'h1;
        end
        // Step the address after the access, so the next word lands one higher
        if (sel == hpc_pkg::HPC_SEL_DATA_INC) begin
          next_address = port_address_reg + hpc_pkg::HPC_ADDR_ONE;
        end
      end
    end
    // A disable drops a half-finished word only without the strap; with it the parked first byte still pairs with the next second byte
    if (!port_enable_in) begin
      next_state = HPC_ST_IDLE;
    end
  end

  // Engine registers; every host-facing pin changes only here, so the host sees clean levels.
  // Read data holds after the strobe ends, so the host can take it a cycle later.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state             <= HPC_ST_IDLE;
      strobe_d          <= 1'h0;
      port_address_reg  <= hpc_pkg::HPC_WORD_RESET;
      port_data_reg     <= hpc_pkg::HPC_WORD_RESET;
      port_control_reg  <= hpc_pkg::HPC_WORD_RESET;
      low_hold          <= 8'h00;
      link.port_data    <= 8'h00;
      link.port_data_oe <= 1'h0;
      link.port_ready_out <= hpc_pkg::HPC_READY_RESET;
      link.port_ready_oe  <= 1'h0;
      core_wr           <= 1'h0;
      core_rd           <= 1'h0;
      core_addr         <= hpc_pkg::HPC_WORD_RESET;
    end else begin
      state             <= next_state;
      strobe_d          <= strobe_now;
      port_address_reg  <= next_address;
      port_data_reg     <= next_data;
      port_control_reg  <= next_control;
      low_hold          <= next_low_hold;
      link.port_data    <= next_port_data;
      link.port_data_oe <= next_port_data_oe;
      link.port_ready_out <= next_ready;
      link.port_ready_oe  <= next_ready_oe;
      core_wr           <= next_wr;
      core_rd           <= next_rd;
      core_addr         <= next_core_addr;
    end
  end

  // Non-multiplexed byte order: a parked first byte makes the next strobe the second.
  // A stray strobe therefore shifts the pairing until a disable or reset.
  assign first_byte = (state == HPC_ST_BUSY); // Second byte follows a held first byte

endmodule : hpc_device

// File: verilog/hpc_pkg.sv
/*
  Shared constants and types for the host port pin-control link: access-control codes,
  register selection and reset values.
  Assumes both ends run on one 50 MHz device clock.
*/
package hpc_pkg;

  // Access-control code, high bit then low bit
  typedef enum logic [1:0] {
    HPC_SEL_CONTROL = 2'h0,
    HPC_SEL_DATA_INC = 2'h1,
    HPC_SEL_ADDRESS = 2'h2,
    HPC_SEL_DATA = 2'h3
  } hpc_sel_t;

  localparam int unsigned HPC_CLK_MHZ     = 50;
  localparam int unsigned HPC_DATA_W      = 8;
  localparam int unsigned HPC_ADDR_W      = 16;
  localparam logic        HPC_DIR_READ    = 1'h1;
  localparam logic        HPC_DIR_WRITE   = 1'h0;
  localparam logic        HPC_READY_RESET = 1'h1;
  localparam logic [15:0] HPC_WORD_RESET  = 16'h0000;
  localparam logic [15:0] HPC_ADDR_ONE    = 16'h0001;

endpackage : hpc_pkg

// File: verilog/hpc_link_if.sv
/*
  Pin bundle between an external host and the host port pin-control end.
  Two-way data pins are carried as separate signals per direction; each end reads the other's signal directly.
*/
`timescale 1ns/10ps
interface hpc_link_if;
  logic                          port_select_n;
  logic                          read_write_sel;
  logic                          access_ctrl_lo;
  logic                          access_ctrl_hi;
  logic                          byte_ident_in;
  logic                          address_strobe_in;
  logic                          data_strobe_one;
  logic                          data_strobe_two;
  logic [hpc_pkg::HPC_DATA_W-1:0] host_data;
  logic [hpc_pkg::HPC_DATA_W-1:0] port_data;
  logic                          port_data_oe;
  logic                          port_ready_out;
  logic                          port_ready_oe;

  modport device (
    input  port_select_n, read_write_sel, access_ctrl_lo, access_ctrl_hi, byte_ident_in,
    input  address_strobe_in, data_strobe_one, data_strobe_two, host_data,
    output port_data, port_data_oe, port_ready_out, port_ready_oe
  );
  modport host (
    output port_select_n, read_write_sel, access_ctrl_lo, access_ctrl_hi, byte_ident_in,
    output address_strobe_in, data_strobe_one, data_strobe_two, host_data,
    input  port_data, port_data_oe, port_ready_out, port_ready_oe
  );
endinterface : hpc_link_if

// File: verilog/hpc_host.sv
/*
  Host end: turns a user word request into a two-byte pin cycle on the host port.
  Assumes the device end samples pins on the same sys_clk.
*/
`timescale 1ns/10ps
module hpc_host (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  // User request
  input  wire logic                          req_valid,
  input  wire logic [1:0]                    req_sel,
  input  wire logic                          req_read,
  input  wire logic [15:0]                   req_wdata,
  output logic                               req_busy,
  output logic                               rsp_valid,
  output logic      [15:0]                   rsp_rdata,
  // Pins
  hpc_link_if.host                           link
);

  typedef enum logic [2:0] {
    HPC_H_IDLE = 3'h0,
    HPC_H_LO_ON = 3'h1,
    HPC_H_LO_OFF = 3'h2,
    HPC_H_HI_ON = 3'h3,
    HPC_H_HI_OFF = 3'h4
  } hpc_host_st_t;

  hpc_host_st_t state;
  hpc_host_st_t next_state;
  logic [1:0]   sel_q;
  logic [1:0]   next_sel;
  logic         rd_q;
  logic         next_rd;
  logic [15:0]  wd_q;
  logic [15:0]  next_wd;
  logic [15:0]  next_rdata;
  logic         next_rsp;

  // Read bytes are taken in the cycle after their strobe, once the device has registered them
  always_comb begin
    next_state = state;
    next_sel   = sel_q;
    next_rd    = rd_q;
    next_wd    = wd_q;
    next_rdata = rsp_rdata;
    next_rsp   = 1'h0;
    unique case (state)
      HPC_H_IDLE: if (req_valid) begin
        next_sel   = req_sel;
        next_rd    = req_read;
        next_wd    = req_wdata;
        next_state = HPC_H_LO_ON;
      end
      HPC_H_LO_ON: next_state = HPC_H_LO_OFF;
      HPC_H_LO_OFF: begin
        next_rdata[7:0] = link.port_data;
        next_state      = HPC_H_HI_ON;
      end
      HPC_H_HI_ON: next_state = HPC_H_HI_OFF;
      HPC_H_HI_OFF: begin
        next_rdata[15:8] = link.port_data;
        next_rsp         = 1'h1;
        next_state       = HPC_H_IDLE;
      end
      default: next_state = HPC_H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= HPC_H_IDLE;
      sel_q     <= 2'h0;
      rd_q      <= 1'h0;
      wd_q      <= 16'h0000;
      rsp_rdata <= 16'h0000;
      rsp_valid <= 1'h0;
    end else begin
      state     <= next_state;
      sel_q     <= next_sel;
      rd_q      <= next_rd;
      wd_q      <= next_wd;
      rsp_rdata <= next_rdata;
      rsp_valid <= next_rsp;
    end
  end

  // Pin drive follows state; strobe low during the two ON states
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_busy               <= 1'h0;
      link.port_select_n     <= 1'h1;
      link.read_write_sel    <= 1'h1;
      link.access_ctrl_lo    <= 1'h0;
      link.access_ctrl_hi    <= 1'h0;
      link.byte_ident_in     <= 1'h0;
      link.address_strobe_in <= 1'h1;
      link.data_strobe_one   <= 1'h1;
      link.data_strobe_two   <= 1'h1;
      link.host_data         <= 8'h00;
    end else begin
      req_busy               <= (next_state != HPC_H_IDLE);
      link.port_select_n     <= (next_state == HPC_H_IDLE);
      link.read_write_sel    <= next_rd;
      link.access_ctrl_lo    <= next_sel[0];
      link.access_ctrl_hi    <= next_sel[1];
      link.byte_ident_in     <= (next_state == HPC_H_HI_ON || next_state == HPC_H_HI_OFF);
      link.address_strobe_in <= 1'h1;
      link.data_strobe_one   <= 1'h1;
      link.data_strobe_two   <= !(next_state == HPC_H_LO_ON || next_state == HPC_H_HI_ON);
      link.host_data         <= (next_state == HPC_H_HI_ON || next_state == HPC_H_HI_OFF) ?
                                next_wd[15:8] : next_wd[7:0];
    end
  end

endmodule : hpc_host

// File: verification/hpc_link_assertions.sv
/*
  Pin-level checks on the host port link between host end and device end.
  Assumes one clock and the active-low reset of both ends.
*/
`timescale 1ns/10ps
module hpc_link_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Host pins
  input wire logic port_select_n,
  input wire logic read_write_sel,
  input wire logic access_ctrl_lo,
  input wire logic access_ctrl_hi,
  input wire logic byte_ident_in,
  input wire logic data_strobe_one,
  input wire logic data_strobe_two,
  // Device pins
  input wire logic port_data_oe,
  input wire logic port_ready_out,
  input wire logic port_ready_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Either strobe low counts as active
  wire strobe_on = !(data_strobe_one && data_strobe_two);

  // One strobed byte, then the strobe released
  sequence s_byte(bit ident);
    strobe_on && !port_select_n && (byte_ident_in == ident) ##1 !strobe_on;
  endsequence
  sequence s_read_start;
    !port_select_n && read_write_sel && port_ready_oe && $rose(strobe_on);
  endsequence

  property p_walk;
    $fell(port_select_n) |-> s_byte(1'b0) ##1 s_byte(1'b1) ##1 port_select_n;
  endproperty
  property p_ready;
    port_ready_out;
  endproperty
  property p_idle_float;
    port_select_n && $past(port_select_n) |-> !port_data_oe;
  endproperty
  property p_write_float;
    !read_write_sel && !$past(read_write_sel) |-> !port_data_oe;
  endproperty
  property p_read_drive;
    s_read_start |=> port_data_oe;
  endproperty
  property p_disabled;
    !port_ready_oe |-> !port_data_oe;
  endproperty
  property p_code_stable;
    !port_select_n && !$past(port_select_n) |-> $stable({access_ctrl_hi, access_ctrl_lo, read_write_sel});
  endproperty
  property p_reset_in;
    $rose(rst_b) |-> !port_data_oe && port_select_n;
  endproperty

  a_walk: assert property (p_walk) else $error("byte pair walk broken");
  a_ready: assert property (p_ready) else $error("ready not high");
  a_idle_float: assert property (p_idle_float) else $error("data driven while idle");
  a_write_float: assert property (p_write_float) else $error("data driven on write");
  a_read_drive: assert property (p_read_drive) else $error("read data not driven");
  a_disabled: assert property (p_disabled) else $error("data driven while disabled");
  a_code_stable: assert property (p_code_stable) else $error("code moved in cycle");
  a_reset_in: assert property (p_reset_in) else $error("pins driven after reset");
endmodule : hpc_link_assertions

// File: verification/host_port_pin_control_test.sv
/*
  Testbench joining host end and device end; drives the user and core sides.
  Assumes the hand-over walk: one response pulse per word cycle.
*/
`timescale 1ns/10ps
module host_port_pin_control_test;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        strap = 1'b1;
  logic        enable = 1'b1;
  logic [15:0] core_rdata = 16'h0000;
  logic [15:0] core_addr, core_wdata, ctl_reg, rsp_rdata, wr_addr, wr_data, rd_addr;
  logic        core_wr, core_rd, mux_mode, rsp_valid, req_busy;
  logic        req_valid = 1'b0;
  logic [1:0]  req_sel = 2'h0;
  logic        req_read = 1'b0;
  logic [15:0] req_wdata = 16'h0000;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          wr_count = 0;
  int          rd_count = 0;

  hpc_link_if link ();
  hpc_device u_hpc_device (.sys_clk(sys_clk), .rst_b(rst_b), .strap_select_pin(strap), .port_enable_in(enable),
    .link(link.device), .core_rdata(core_rdata), .core_addr(core_addr), .core_wdata(core_wdata),
    .core_wr(core_wr), .core_rd(core_rd), .port_control_reg(ctl_reg), .mux_mode(mux_mode));
  hpc_host u_hpc_host (.sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid), .req_sel(req_sel),
    .req_read(req_read), .req_wdata(req_wdata), .req_busy(req_busy), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .link(link.host));
  hpc_link_assertions u_hpc_link_assertions (.sys_clk(sys_clk), .rst_b(rst_b),
    .port_select_n(link.port_select_n), .read_write_sel(link.read_write_sel),
    .access_ctrl_lo(link.access_ctrl_lo), .access_ctrl_hi(link.access_ctrl_hi),
    .byte_ident_in(link.byte_ident_in), .data_strobe_one(link.data_strobe_one),
    .data_strobe_two(link.data_strobe_two), .port_data_oe(link.port_data_oe),
    .port_ready_out(link.port_ready_out), .port_ready_oe(link.port_ready_oe));

  // Free-running 50 MHz clock
  initial forever #10 sys_clk = ~sys_clk;

  // Core pulse capture at the falling edge, where outputs are settled; hang guard far above need
  always @(negedge sys_clk) begin
    cycles++;
    if (core_wr === 1'b1) begin
      wr_addr = core_addr;
      wr_data = core_wdata;
      wr_count++;
    end
    if (core_rd === 1'b1) begin
      rd_addr = core_addr;
      rd_count++;
    end
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end

  task check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task complete_run();
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  // One word cycle through the host end; bounded wait for its response
  task xfer(input logic [1:0] sel, input logic rd, input logic [15:0] wd);
    int n;
    req_valid = 1'b1;
    req_sel = sel;
    req_read = rd;
    req_wdata = wd;
    @(negedge sys_clk);
    req_valid = 1'b0;
    check("req_busy", 16'h0001, {15'h0000, req_busy});
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    check("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
    check("req_idle", 16'h0000, {15'h0000, req_busy});
    @(negedge sys_clk);
  endtask : xfer

  // Strap held through release, then idle pins and reset values
  task t_reset(input logic s);
    rst_b = 1'b0;
    strap = s;
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    @(negedge sys_clk);
    check("mux_mode", {15'h0000, s}, {15'h0000, mux_mode});
    check("data_oe", 16'h0000, {15'h0000, link.port_data_oe});
    check("ready", 16'h0001, {15'h0000, link.port_ready_out});
    check("ctl_reg", 16'h0000, ctl_reg);
  endtask : t_reset

  task t_control(input logic [15:0] v);
    xfer(hpc_pkg::HPC_SEL_CONTROL, hpc_pkg::HPC_DIR_WRITE, v);
    check("ctl_reg", v, ctl_reg);
  endtask : t_control

  // Plain data write, then two back-to-back incrementing writes
  task t_addr_data();
    xfer(hpc_pkg::HPC_SEL_ADDRESS, hpc_pkg::HPC_DIR_WRITE, 16'h1234);
    xfer(hpc_pkg::HPC_SEL_DATA, hpc_pkg::HPC_DIR_WRITE, 16'hbeef);
    check("wr_addr", 16'h1234, wr_addr);
    check("wr_data", 16'hbeef, wr_data);
    for (int i = 0; i < 2; i++) begin
      xfer(hpc_pkg::HPC_SEL_DATA_INC, hpc_pkg::HPC_DIR_WRITE, 16'h00a0 + 16'(i));
      check("inc_addr", 16'h1234 + 16'(i), wr_addr);
      check("inc_data", 16'h00a0 + 16'(i), wr_data);
    end
  endtask : t_addr_data

  // A read returns core data and leaves the last write alone
  task t_read();
    int w0;
    int r0;
    core_rdata = 16'hc0de;
    w0 = wr_count;
    r0 = rd_count;
    xfer(hpc_pkg::HPC_SEL_DATA, hpc_pkg::HPC_DIR_READ, 16'hffff);
    check("rsp_rdata", 16'hc0de, rsp_rdata);
    check("no_write", 16'(w0), 16'(wr_count));
    check("rd_pulse", 16'(r0 + 1), 16'(rd_count));
    check("rd_addr", 16'h1236, rd_addr);
  endtask : t_read

  // Disabled port floats its outputs and takes no write
  task t_disabled();
    enable = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("ready_oe", 16'h0000, {15'h0000, link.port_ready_oe});
    xfer(hpc_pkg::HPC_SEL_CONTROL, hpc_pkg::HPC_DIR_WRITE, 16'h0f0f);
    check("ctl_held", 16'h5a3c, ctl_reg);
    enable = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("ready_oe_on", 16'h0001, {15'h0000, link.port_ready_oe});
  endtask : t_disabled

  // Main sequence: multiplexed mode, then strap low
  initial begin
    @(negedge sys_clk);
    t_reset(1'b1);
    t_control(16'h5a3c);
    t_addr_data();
    t_read();
    t_disabled();
    t_reset(1'b0);
    t_addr_data();
    t_control(16'h00c3);
    complete_run();
  end
endmodule : host_port_pin_control_test
